/* adsb_pkg.sv */
/*
  Shared constants and types of the dual sigma-delta converter back end:
  register byte offsets, status bit positions, reset values, filter sizes,
  input source codes and the packed state of the back end.
  Assumes a single 20 MHz clock domain and a 32-bit Avalon-MM register bus.
*/
package adsb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  // modulator enable divider reload after reset (20 MHz / 39)
  localparam logic [15:0] RATE_DIV_RST = 16'h0026;
  // low power mode slows the modulator rate by four
  localparam logic [1:0] LP_PRESCALE = 2'h3;
  // number of the filter output that is the first to count as settled
  localparam logic [1:0] SETTLE_NOCHOP = 2'h3;
  localparam logic [1:0] SETTLE_CHOP = 2'h2;
  // repeats of the previous modulator bit in a row that flag a fast overrange
  localparam logic [5:0] OVR_RUN = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // filter sizes: decimation 2^6..2^8, full scale 2^24 needs 25 bits
  localparam int SINC_W = 25;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_RATE = 6'h04;
  localparam logic [5:0] ADDR_STATUS = 6'h08;
  localparam logic [5:0] ADDR_MASK = 6'h0c;
  localparam logic [5:0] ADDR_CUR_RES = 6'h10;
  localparam logic [5:0] ADDR_VT_A = 6'h14;
  localparam logic [5:0] ADDR_VT_B = 6'h18;
  localparam logic [5:0] ADDR_CNT_LIM = 6'h1c;
  localparam logic [5:0] ADDR_CNT_VAL = 6'h20;
  localparam logic [5:0] ADDR_THRESH = 6'h24;
  localparam logic [5:0] ADDR_ACC = 6'h28;

  ////////////////////////////////////////////////////////////////////////////
  // status bit positions: low byte interrupts, high byte flags only
  localparam int ST_CUR_RDY = 0;
  localparam int ST_VT_RDY = 1;
  localparam int ST_CNT = 2;
  localparam int ST_THR = 3;
  localparam int ST_OVR = 4;
  localparam int ST_CUR_SETTLED = 8;
  localparam int ST_VT_SETTLED = 9;

  // reset values
  localparam logic [15:0] CNT_LIM_RST = 16'h0001;
  localparam logic [15:0] THRESH_RST = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  // voltage/temperature input sources; code 2'b11 is not a source
  typedef enum logic [1:0] {
    SRC_VBAT = 2'b00,
    SRC_EXT_TEMP = 2'b01,
    SRC_CHIP_TEMP = 2'b10
  } adsb_src_t;

  // control register, bits [9:0] from msb to lsb
  typedef struct packed {
    logic [1:0] decim_sel;
    adsb_src_t vt_src;
    logic ovr_en;
    logic acc_en;
    logic lp_mode;
    logic chop;
    logic vt_en;
    logic cur_en;
  } adsb_ctrl_t;

  // one sinc3 decimator with its settle counter and output strobe
  typedef struct packed {
    logic [SINC_W-1:0] i1;
    logic [SINC_W-1:0] i2;
    logic [SINC_W-1:0] i3;
    logic [SINC_W-1:0] c1;
    logic [SINC_W-1:0] c2;
    logic [SINC_W-1:0] c3;
    logic [7:0] dcnt;
    logic [1:0] settle;
    logic fire;
    logic [15:0] word;
  } adsb_sinc_t;

  // all state of the back end
  typedef struct packed {
    logic [1:0] cur_sync;
    logic [1:0] vt_sync;
    logic [15:0] div_cnt;
    logic [1:0] lp_cnt;
    logic mod_en;
    adsb_sinc_t cur;
    adsb_sinc_t vt;
    logic cur_last;
    logic [5:0] run;
    adsb_ctrl_t ctrl;
    logic [15:0] rate_div;
    logic [7:0] status;
    logic [7:0] mask;
    logic [15:0] cur_res;
    logic [15:0] vt_a;
    logic [15:0] vt_b;
    logic [15:0] cnt_lim;
    logic [15:0] cnt_val;
    logic [15:0] thresh;
    logic [31:0] acc;
    logic ack;
    logic [31:0] rdata;
  } adsb_state_t;

endpackage

/* adsb_backend.sv */
/*
  Digital back end of two sigma-delta converter channels: sinc3 decimation,
  settling suppression, result registers with ready flags, conversion counter,
  threshold comparator, fast overrange detector, result accumulator, source
  select of the voltage/temperature channel, and the Avalon-MM register slave.
  Assumes the modulator bit streams arrive asynchronously on pins and that the
  modulators take one bit per mod_sample_en pulse.
*/
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// [R1] The current channel decimates its bit stream by sinc3 into 16-bit results at 4 Hz to 8 kHz.
// [R2] In low power mode the modulator rate drops by four, so output rates span 1 Hz to 2 kHz.
// [R3] Completed current conversions are counted and an interrupt is raised at the set number.
// [R4] Each current result above the threshold register raises an interrupt.
// [R5] An enableable fast overrange check flags a long run of equal modulator bits.
// [R6] With accumulation on, every current result is added into a 32-bit accumulator.
// [R7] The first settled current result is the third output, or the second with chopping on.
// [R8] The voltage/temperature input is one of exactly three sources; other codes are refused.
// [R9] The voltage/temperature channel uses the same sinc3 scheme with 16-bit results.
// [R10] Selecting the battery attenuator input enables its buffers with no other setting; the code also requires vt_en.
// [R11] After a voltage/temperature source switch the first settled result is the third output.
// [R12] Voltage/temperature results are unipolar codes over a fixed range with no gain stage.
// [R13] Reading the current result clears all ready flags, or a vt result if current is off.
// [R14] A result register is not overwritten while its ready flag is set unless the core sleeps.
// [R15] The low eight status bits are maskable into one interrupt; the upper ones are flags.
// [R16] Each channel pulses result valid for one cycle per settled filter output.
module adsb_backend
  import adsb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // modulators and analog front end
  input wire logic cur_mod_bit,
  input wire logic vt_mod_bit,
  output logic mod_sample_en,
  output logic [1:0] vt_src_sel,
  output logic atten_buf_en,
  // power state of the processor core
  input wire logic core_powered_down,
  // result strobes
  output logic cur_result_valid,
  output logic [15:0] cur_result,
  output logic vt_result_valid,
  output logic [15:0] vt_result,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // filter helpers

  // scale a sinc3 output of 3k bits to 16 bits, saturating at full scale
  function automatic logic [15:0] sinc_norm(logic [SINC_W-1:0] v, logic [1:0] dsel);
    logic [SINC_W-1:0] sh;
    sh = '0;
    unique case (dsel)
      2'h0: sh = v >> 2;
      2'h1: sh = v >> 5;
      default: sh = v >> 8;
    endcase
    if (|sh[SINC_W-1:16]) begin
      return 16'hffff;
    end
    return sh[15:0];
  endfunction

  // one modulator bit into the sinc3 decimator
  function automatic adsb_sinc_t sinc_step(adsb_sinc_t c, logic b, logic [1:0] dsel,
                                           logic [1:0] need);
    adsb_sinc_t n;
    logic [SINC_W-1:0] y1;
    logic [SINC_W-1:0] y2;
    logic [SINC_W-1:0] y3;
    logic [7:0] last;
    n = c;
    y1 = '0;
    y2 = '0;
    y3 = '0;
    last = (dsel == 2'h0) ? 8'h3f : ((dsel == 2'h1) ? 8'h7f : 8'hff);
    n.fire = 1'b0;
    // integrators at the modulator rate
    // integrators wrap modulo 2^SINC_W; the differences stay exact
    n.i1 = c.i1 + {{(SINC_W-1){1'b0}}, b};
    n.i2 = c.i2 + c.i1;
    n.i3 = c.i3 + c.i2;
    if (c.dcnt >= last) begin
      // differentiators at the output rate
      n.dcnt = 8'h00;
      y1 = c.i3 - c.c1;
      y2 = y1 - c.c2;
      y3 = y2 - c.c3;
      n.c1 = c.i3;
      n.c2 = y1;
      n.c3 = y2;
      n.word = sinc_norm(y3, dsel);
      // [R16] strobe only when settled
      if (({1'b0, c.settle} + 3'h1) >= {1'b0, need}) begin
        n.fire = 1'b1;
      end
      if (c.settle < need) begin
        n.settle = c.settle + 2'h1;
      end
    end else begin
      n.dcnt = c.dcnt + 8'h01;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  adsb_state_t q;
  adsb_state_t d;
  logic [1:0] cur_need;
  logic [7:0] st_set;
  logic [7:0] st_clr;
  logic [15:0] flags;
  logic [31:0] rd;
  logic [15:0] cnt_next;
  logic cur_upd;
  logic vt_upd;
  logic rdy_clear;

  // [R7] settle depth depends on chopping
  assign cur_need = q.ctrl.chop ? SETTLE_CHOP : SETTLE_NOCHOP;

  // [R15] high byte: live flags that never interrupt
  assign flags = {6'h00, q.vt.settle >= SETTLE_NOCHOP, q.cur.settle >= cur_need, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    st_set = 8'h00;
    st_clr = 8'h00;
    rd = 32'h0000_0000;
    cnt_next = q.cnt_val + 16'h0001;
    rdy_clear = 1'b0;
    d.mod_en = 1'b0;

    // pin inputs pass two flip-flops
    d.cur_sync = {q.cur_sync[0], cur_mod_bit};
    d.vt_sync = {q.vt_sync[0], vt_mod_bit};

    // [R1] modulator rate divider sets the output rate
    // a rate_div of zero gives a sample pulse every clock outside low power mode
    if (q.div_cnt >= q.rate_div) begin
      d.div_cnt = 16'h0000;
      d.lp_cnt = q.lp_cnt + 2'h1;
      // [R2] low power takes every fourth pulse
      d.mod_en = !q.ctrl.lp_mode || (q.lp_cnt == LP_PRESCALE);
    end else begin
      d.div_cnt = q.div_cnt + 16'h0001;
    end

    // [R1] current channel decimation; disabling restarts settling
    d.cur.fire = 1'b0;
    if (!q.ctrl.cur_en) begin
      d.cur = '0;
    end else if (q.mod_en) begin
      d.cur = sinc_step(q.cur, q.cur_sync[1], q.ctrl.decim_sel, cur_need);
    end

    // [R9] same decimator on the voltage/temperature channel
    d.vt.fire = 1'b0;
    if (!q.ctrl.vt_en) begin
      d.vt = '0;
    end else if (q.mod_en) begin
      d.vt = sinc_step(q.vt, q.vt_sync[1], q.ctrl.decim_sel, SETTLE_NOCHOP);
    end

    // [R5] fast overrange: long run of equal bits
    // the run saturates, so one long run flags only once
    if (!q.ctrl.ovr_en || !q.ctrl.cur_en) begin
      d.run = 6'h00;
    end else if (q.mod_en) begin
      d.cur_last = q.cur_sync[1];
      if (q.cur_sync[1] == q.cur_last) begin
        if (q.run == (OVR_RUN - 6'h01)) begin
          st_set[ST_OVR] = 1'b1;
        end
        if (q.run != OVR_RUN) begin
          d.run = q.run + 6'h01;
        end
      end else begin
        d.run = 6'h00;
      end
    end

    // [R14] result registers hold until their ready flag is cleared
    // a sleeping core cannot read, so then the newest result always wins
    cur_upd = !q.status[ST_CUR_RDY] || core_powered_down;
    vt_upd = !q.status[ST_VT_RDY] || core_powered_down;

    // current channel result handling
    if (q.cur.fire) begin
      st_set[ST_CUR_RDY] = 1'b1;
      if (cur_upd) begin
        d.cur_res = q.cur.word;
      end
      // [R3] conversion count reached
      if (cnt_next >= q.cnt_lim) begin
        st_set[ST_CNT] = 1'b1;
        d.cnt_val = 16'h0000;
      end else begin
        d.cnt_val = cnt_next;
      end
      // [R4] threshold exceeded
      if (q.cur.word > q.thresh) begin
        st_set[ST_THR] = 1'b1;
      end
      // [R6] accumulate every result
      // the sum wraps silently after about 65536 full-scale results
      if (q.ctrl.acc_en) begin
        d.acc = q.acc + {16'h0000, q.cur.word};
      end
    end
    if (!q.ctrl.acc_en) begin
      d.acc = 32'h0000_0000;
    end

    // [R12] unipolar code, battery to one register, temperatures to the other
    if (q.vt.fire) begin
      st_set[ST_VT_RDY] = 1'b1;
      if (vt_upd && (q.ctrl.vt_src == SRC_VBAT)) begin
        d.vt_a = q.vt.word;
      end else if (vt_upd) begin
        d.vt_b = q.vt.word;
      end
    end

    // register read mux, captured in the first cycle of a request
    unique case (avs_address)
      ADDR_CTRL: rd = {22'h000000, q.ctrl};
      ADDR_RATE: rd = {16'h0000, q.rate_div};
      ADDR_STATUS: rd = {16'h0000, flags | {8'h00, q.status}};
      ADDR_MASK: rd = {24'h000000, q.mask};
      ADDR_CUR_RES: rd = {16'h0000, q.cur_res};
      ADDR_VT_A: rd = {16'h0000, q.vt_a};
      ADDR_VT_B: rd = {16'h0000, q.vt_b};
      ADDR_CNT_LIM: rd = {16'h0000, q.cnt_lim};
      ADDR_CNT_VAL: rd = {16'h0000, q.cnt_val};
      ADDR_THRESH: rd = {16'h0000, q.thresh};
      ADDR_ACC: rd = q.acc;
      default: rd = 32'h0000_0000;
    endcase

    // bus slave: one wait cycle, then the access completes; a request
    // still held after completion starts a fresh access, so back-to-back
    // transfers cost two cycles each
    d.ack = (avs_read || avs_write) && !q.ack;
    // read data is captured on reads only and stands until the next read
    if (avs_read && !q.ack) begin
      d.rdata = rd;
    end

    // writes take effect at the completing edge
    if (q.ack && avs_write) begin
      unique case (avs_address)
        ADDR_CTRL: begin
          d.ctrl.cur_en = avs_writedata[0];
          d.ctrl.vt_en = avs_writedata[1];
          d.ctrl.chop = avs_writedata[2];
          d.ctrl.lp_mode = avs_writedata[3];
          d.ctrl.acc_en = avs_writedata[4];
          d.ctrl.ovr_en = avs_writedata[5];
          d.ctrl.decim_sel = avs_writedata[9:8];
          // [R8] only the three real sources are accepted
          if (avs_writedata[7:6] != 2'b11) begin
            d.ctrl.vt_src = adsb_src_t'(avs_writedata[7:6]);
            // [R11] a source switch restarts the whole filter, which keeps
            // samples of the old source out of the first settled word
            if (avs_writedata[7:6] != q.ctrl.vt_src) begin
              d.vt = '0;
            end
          end
        end
        ADDR_RATE: d.rate_div = avs_writedata[15:0];
        ADDR_STATUS: st_clr = avs_writedata[7:0];
        ADDR_MASK: d.mask = avs_writedata[7:0];
        ADDR_CNT_LIM: d.cnt_lim = avs_writedata[15:0];
        ADDR_THRESH: d.thresh = avs_writedata[15:0];
        default: d.rate_div = q.rate_div;
      endcase
    end

    // [R13] reading the current result, or a vt result with the current channel off, clears every ready flag
    if (q.ack && avs_read) begin
      if (avs_address == ADDR_CUR_RES) begin
        rdy_clear = 1'b1;
      end
      if (!q.ctrl.cur_en && ((avs_address == ADDR_VT_A) || (avs_address == ADDR_VT_B))) begin
        rdy_clear = 1'b1;
      end
    end
    if (rdy_clear) begin
      st_clr[ST_CUR_RDY] = 1'b1;
      st_clr[ST_VT_RDY] = 1'b1;
    end

    // sticky status: a new event wins over a clear in the same cycle
    // so a result arriving in the clearing cycle keeps its ready flag
    d.status = (q.status & ~st_clr) | st_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // reset loads constants only; both filters restart from zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.rate_div <= RATE_DIV_RST;
      q.cnt_lim <= CNT_LIM_RST;
      q.thresh <= THRESH_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
  assign mod_sample_en = q.mod_en;
  assign vt_src_sel = q.ctrl.vt_src;
  // [R10] battery input selection with vt_en set powers the attenuator buffers
  assign atten_buf_en = q.ctrl.vt_en && (q.ctrl.vt_src == SRC_VBAT);
  assign cur_result_valid = q.cur.fire;
  assign cur_result = q.cur.word;
  assign vt_result_valid = q.vt.fire;
  assign vt_result = q.vt.word;
  // [R15] masked low status byte into one level interrupt
  assign irq = |(q.status & q.mask);

endmodule // adsb_backend

/* adsb_mod_model.sv */
/*
  Model of the two sigma-delta modulators: one bit per sample pulse.
  Assumes the back end pulses mod_sample_en once for each bit it takes.
*/
`timescale 1ns/1ps
module adsb_mod_model (
  // clock and sample pulse
  input wire logic clk,
  input wire logic mod_sample_en,
  // pattern: 0 zeros, 1 ones, 2 alternating
  input wire logic [1:0] mode,
  // bit streams
  output logic cur_bit,
  output logic vt_bit
);
  logic ph_q = 1'b0;
  ////////////////////////////////////////
  // the stream only steps on a sample pulse, as a modulator would
  always @(posedge clk) begin
    if (mod_sample_en) begin
      ph_q <= ~ph_q;
    end
  end
  assign cur_bit = (mode == 2'h2) ? ph_q : mode[0];
  assign vt_bit = cur_bit;
endmodule // adsb_mod_model

/* adsb_chk.sv */
/*
  Port checker of the converter back end.
  Assumes it is bound to adsb_backend and sees only its ports.
*/
`timescale 1ns/1ps
module adsb_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // front end and strobes
  input wire logic mod_sample_en,
  input wire logic [1:0] vt_src_sel,
  input wire logic atten_buf_en,
  input wire logic cur_result_valid,
  input wire logic vt_result_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // one wait state, none without a request
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state too long");
  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait with no request");
  // read data only moves when a read is captured
  property p_rdata_hold;
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // strobe follows a sample pulse, lasts one cycle, then stays low for eight cycles
  property p_cur_strobe;
    cur_result_valid |-> $past(mod_sample_en) ##1 !cur_result_valid [*8];
  endproperty
  a_cur_strobe: assert property (p_cur_strobe) else $error("current strobe bad");
  property p_vt_strobe;
    vt_result_valid |-> $past(mod_sample_en) ##1 !vt_result_valid [*8];
  endproperty
  a_vt_strobe: assert property (p_vt_strobe) else $error("vt strobe bad");
  // buffers only with the battery source
  property p_atten;
    atten_buf_en |-> vt_src_sel == 2'h0;
  endproperty
  a_atten: assert property (p_atten) else $error("buffers on for other source");
  property p_src_code;
    vt_src_sel != 2'h3;
  endproperty
  a_src_code: assert property (p_src_code) else $error("source code invalid");
  // the source only moves on a completed register write
  property p_src_write;
    $changed(vt_src_sel) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source moved alone");
  c_cur: cover property (cur_result_valid);
  c_vt: cover property (vt_result_valid);
  c_atten: cover property ($rose(atten_buf_en));
endmodule // adsb_chk

bind adsb_backend adsb_chk chk_u (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mod_sample_en(mod_sample_en), .vt_src_sel(vt_src_sel), .atten_buf_en(atten_buf_en),
  .cur_result_valid(cur_result_valid), .vt_result_valid(vt_result_valid));

/* tb_top.sv */
/*
  Self-checking bench of the converter back end over its register bus.
  Assumes the modulator model in adsb_mod_model and rate_div set to 0.
*/
`timescale 1ns/1ps
module tb_top;
  import adsb_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, cur_mod_bit, vt_mod_bit, mod_sample_en, atten_buf_en;
  logic cur_result_valid, vt_result_valid, irq;
  logic [1:0] vt_src_sel, e;
  logic [15:0] cur_result, vt_result;
  logic core_powered_down = 1'b0;
  logic [1:0] mode = 2'h1;
  int mismatches = 0;
  int checks = 0;
  int npul = 0;
  int ncur = 0;
  int nvt = 0;
  int n;
  logic [5:0] ra[8] = '{ADDR_CTRL, ADDR_RATE, ADDR_STATUS, ADDR_MASK, ADDR_CNT_LIM,
    ADDR_THRESH, ADDR_ACC, 6'h3c};
  logic [31:0] rv[8] = '{32'h0, 32'(RATE_DIV_RST), 32'h0, 32'h0, 32'(CNT_LIM_RST),
    32'(THRESH_RST), 32'h0, 32'h0};

  always #25 clk = ~clk;
  // running counts of sample pulses and strobes
  always @(posedge clk) begin
    npul <= npul + int'(mod_sample_en);
    ncur <= ncur + int'(cur_result_valid);
    nvt <= nvt + int'(vt_result_valid);
  end

  adsb_backend dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cur_mod_bit(cur_mod_bit), .vt_mod_bit(vt_mod_bit), .mod_sample_en(mod_sample_en),
    .vt_src_sel(vt_src_sel), .atten_buf_en(atten_buf_en),
    .core_powered_down(core_powered_down), .cur_result_valid(cur_result_valid),
    .cur_result(cur_result), .vt_result_valid(vt_result_valid), .vt_result(vt_result),
    .irq(irq));
  adsb_mod_model mod_u (.clk(clk), .mod_sample_en(mod_sample_en), .mode(mode),
    .cur_bit(cur_mod_bit), .vt_bit(vt_mod_bit));

  ////////////////////////////////////////
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic wr_en, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    if (k >= 20) mismatches++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(rd & m, x);
  endtask
  // wait for the next strobe of one channel, bounded
  task automatic wt(input bit vt, input int n0);
    int k;
    k = 0;
    while ((vt ? nvt : ncur) <= n0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) mismatches++;
  endtask
  // restart with ctrl c and count sample pulses to the first strobe
  task automatic settle(input logic [31:0] c, input bit vt, output int cnt);
    int p0;
    wr(ADDR_CTRL, c);
    p0 = npul;
    wt(vt, vt ? nvt : ncur);
    cnt = npul - p0;
  endtask
  task automatic pulses(input logic [31:0] c, output int cnt);
    int p0;
    wr(ADDR_CTRL, c);
    repeat (8) @(posedge clk);
    p0 = npul;
    repeat (40) @(posedge clk);
    cnt = npul - p0;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rdm(ra[i], 32'hffffffff, rv[i]);
    end
    wr(ADDR_CNT_VAL, 32'h5);
    wr(6'h3c, 32'h5);
    rdm(ADDR_CNT_VAL, 32'hffffffff, 32'h0);
    wr(ADDR_RATE, 32'h0);
    pulses(32'h209, n);
    chk(n, 10);
    pulses(32'h201, n);
    chk(n, 40);
    wr(ADDR_CTRL, 32'h0);
    settle(32'h205, 1'b0, n);
    chk(32'(n > 384 && n <= 520), 1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STATUS, 32'h3);
    settle(32'h201, 1'b0, n);
    chk(32'(n > 640 && n <= 776), 1);
    rdm(ADDR_CUR_RES, 32'hffffffff, 32'hffff);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_THRESH, 32'h8000);
    wr(ADDR_CNT_LIM, 32'h2);
    wr(ADDR_MASK, 32'h1f);
    wr(ADDR_STATUS, 32'hff);
    wr(ADDR_CTRL, 32'h233);
    wt(1'b0, ncur);
    wt(1'b1, 0);
    chk(cur_result, 32'hffff);
    chk(vt_result, 32'hffff);
    chk(irq, 1'b1);
    rdm(ADDR_STATUS, 32'hffffffff, 32'h31b);
    wr(ADDR_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(ADDR_MASK, 32'h1f);
    rdm(ADDR_ACC, 32'hffffffff, 32'hffff);
    rdm(ADDR_CUR_RES, 32'hffffffff, 32'hffff);
    rdm(ADDR_STATUS, 32'hffffffff, 32'h318);
    wr(ADDR_STATUS, 32'h18);
    rdm(ADDR_STATUS, 32'hffffffff, 32'h300);
    chk(irq, 1'b0);
    wt(1'b0, ncur);
    rdm(ADDR_STATUS, 32'h7, 32'h7);
    rdm(ADDR_CNT_VAL, 32'hffffffff, 32'h0);
    rdm(ADDR_ACC, 32'hffffffff, 32'h1fffe);
    rdm(ADDR_CUR_RES, 32'hffff, 32'hffff);
    wt(1'b0, ncur);
    mode <= 2'h0;
    repeat (4) wt(1'b0, ncur);
    chk(cur_result, 32'h0);
    rdm(ADDR_CUR_RES, 32'hffffffff, 32'hffff);
    core_powered_down <= 1'b1;
    wt(1'b0, ncur);
    mode <= 2'h1;
    repeat (4) wt(1'b0, ncur);
    rdm(ADDR_CUR_RES, 32'hffffffff, 32'hffff);
    core_powered_down <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'h233 | (32'(i) << 6));
      e = (i == 3) ? 2'h2 : 2'(i);
      chk(vt_src_sel, e);
      chk(atten_buf_en, e == 2'h0);
      rdm(ADDR_CTRL, 32'hc0, 32'(e) << 6);
    end
    settle(32'h273, 1'b1, n);
    chk(32'(n > 640 && n <= 776), 1);
    rdm(ADDR_VT_B, 32'hffffffff, 32'hffff);
    wr(ADDR_CTRL, 32'h201);
    chk(atten_buf_en, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_STATUS, 32'h3);
    settle(32'h222, 1'b1, n);
    rdm(ADDR_VT_A, 32'hffffffff, 32'hffff);
    rdm(ADDR_STATUS, 32'h3, 32'h0);
    mode <= 2'h2;
    wr(ADDR_CTRL, 32'h223);
    wr(ADDR_STATUS, 32'hff);
    wt(1'b1, nvt);
    rdm(ADDR_STATUS, 32'h10, 32'h0);
    finish_test;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    finish_test;
  end
endmodule // tb_top
